// File: tb/alr_host_model.sv
// bus master model of the host reading the sensor results
`timescale 1ns/100ps
`default_nettype none

module alr_host_model (
    input wire logic i_clk,
    input wire logic i_dev_oe,
    output logic o_scl,
    output logic o_sda
);
    // eight clocks a half period, twice the device's oversampling need
    localparam int HALF = 8;
    logic pull_r = 1'b0;
    logic scl_r = 1'b1;

    // wired data line with pull-up: low while either party pulls
    assign o_sda = ~(pull_r | i_dev_oe);
    assign o_scl = scl_r;

    task automatic half_bit();
        repeat (HALF) @(posedge i_clk);
    endtask : half_bit

    // data falls with clock high; also serves as repeated start
    task automatic start();
        pull_r <= 1'b0;
        half_bit();
        scl_r <= 1'b1;
        half_bit();
        pull_r <= 1'b1;
        half_bit();
        scl_r <= 1'b0;
        half_bit();
    endtask : start

    task automatic stop();
        pull_r <= 1'b1;
        half_bit();
        scl_r <= 1'b1;
        half_bit();
        pull_r <= 1'b0;
        half_bit();
    endtask : stop

    // data set while clock low, sampled at end of the high phase
    task automatic bit_io(input logic b, output logic s);
        pull_r <= ~b;
        half_bit();
        scl_r <= 1'b1;
        half_bit();
        s = o_sda;
        scl_r <= 1'b0;
        half_bit();
    endtask : bit_io

    task automatic xfer(input logic [7:0] tx, input logic hack,
                        output logic [7:0] rx, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(~hack, s);
        acked = ~s;
    endtask : xfer
endmodule : alr_host_model

`default_nettype wire

// File: tb/alr_readout_asserts.sv
// port checks of the ambient light readout block
`timescale 1ns/100ps
`default_nettype none

module alr_readout_asserts
    import alr_pkg::*;
#(
    parameter int CONV_CYCLES = ALR_CONV_CYCLES,
    parameter int FRAME_CYCLES = ALR_FRAME_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire alr_ctrl_t i_ctrl,
    input wire logic [15:0] i_light_sample,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [15:0] o_result,
    input wire logic o_result_stb
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    int gap_r;
    logic seen_r;
    logic same_r;
    alr_ctrl_t last_r;

    // cycles since the last result pulse, and whether controls stayed put
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            gap_r <= 0;
            seen_r <= 1'b0;
            same_r <= 1'b0;
            last_r <= '0;
        end else if (o_result_stb) begin
            gap_r <= 1;
            seen_r <= 1'b1;
            same_r <= 1'b1;
            last_r <= i_ctrl;
        end else begin
            gap_r <= gap_r + 1;
            if (i_ctrl != last_r) begin
                same_r <= 1'b0;
            end
        end
    end

    AST_SDA_OUT_LOW: assert property (o_sda_out == 1'b0)
        else $error("open drain data output not low");
    AST_RESET_QUIET: assert property (i_resetn && !$past(i_resetn) |->
        !o_sda_oe && !o_result_stb && o_result == ALR_RESULT_RESET)
        else $error("outputs not cleared by reset");
    AST_STB_ONE: assert property (o_result_stb |=> !o_result_stb)
        else $error("result pulse longer than one cycle");
    AST_RESULT_HOLD: assert property (!o_result_stb |-> $stable(o_result))
        else $error("result changed without pulse");
    AST_IDLE_QUIET: assert property (!i_ctrl.enable [*8] |=> !o_result_stb)
        else $error("result pulse while disabled");
    AST_CONT_GAP: assert property (o_result_stb && seen_r && same_r &&
        i_ctrl == last_r && i_ctrl.enable && i_ctrl.continuous |->
        gap_r == (CONV_CYCLES << i_ctrl.avg_log2))
        else $error("continuous result spacing wrong");
    AST_STD_FRAME: assert property (o_result_stb && seen_r && same_r &&
        i_ctrl == last_r && i_ctrl.enable && !i_ctrl.continuous |->
        gap_r >= FRAME_CYCLES && gap_r <= FRAME_CYCLES + 3)
        else $error("standard result not one frame apart");
    AST_SDA_STILL: assert property (i_scl && $past(i_scl) |->
        $stable(o_sda_oe))
        else $error("data line moved while bus clock high");
    AST_OE_HOLD: assert property ($rose(o_sda_oe) |->
        o_sda_oe throughout (##[1:40] $fell(i_scl)))
        else $error("data drive dropped before clock fall");
endmodule : alr_readout_asserts

bind alr_readout alr_readout_asserts #(
    .CONV_CYCLES(CONV_CYCLES),
    .FRAME_CYCLES(FRAME_CYCLES)
) alr_readout_asserts_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
    .i_ctrl(i_ctrl), .i_light_sample(i_light_sample),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_result(o_result),
    .o_result_stb(o_result_stb)
);

`default_nettype wire

// File: tb/test_alr_readout.sv
// self-checking bench of the ambient light readout block
`timescale 1ns/100ps
`default_nettype none

module test_alr_readout
    import alr_pkg::*;
;
    // short counts keep the run small; frame still fits 128 conversions
    localparam int CONV = 8;
    localparam int FRAME = 2000;
    localparam int LIMIT = 80000;
    localparam logic [2:0] LGS [3] = '{3'h0, 3'h3, 3'h7};
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    alr_ctrl_t ctrl = '0;
    logic [15:0] sample = 16'h0000;
    logic scl;
    logic sda;
    logic oe;
    logic stb;
    logic [15:0] result;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    alr_readout #(.CONV_CYCLES(CONV), .FRAME_CYCLES(FRAME)) alr_readout_inst (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
        .i_ctrl(ctrl), .i_light_sample(sample), .o_sda_out(),
        .o_sda_oe(oe), .o_result(result), .o_result_stb(stb));
    alr_host_model alr_host_model_inst (
        .i_clk(i_clk), .i_dev_oe(oe), .o_scl(scl), .o_sda(sda));

    always #5 i_clk = ~i_clk;

    // hang guard
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    // edges until a result pulse is seen, bounded
    task automatic wait_stb(input int limit, output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (stb !== 1'b1 && n < limit);
    endtask : wait_stb

    task automatic run_mode(input logic cont, input logic [2:0] lg);
        int n;
        ctrl <= '0;
        sample <= {4'ha, 1'b0, lg, 7'h2b, cont};
        repeat (4) @(posedge i_clk);
        ctrl <= '{enable: 1'b1, continuous: cont, avg_log2: lg};
        wait_stb(3 * FRAME, n);
        check(result, sample, "average");
        // enable seen one edge late, publish and mirror add two more
        if (cont) begin
            check(16'(n), 16'((CONV << lg) + 3), "first result");
        end else begin
            check(16'(n), 16'(FRAME + 3), "first frame");
        end
        wait_stb(3 * FRAME, n);
        if (cont) begin
            check(16'(n), 16'(CONV << lg), "gap");
        end else begin
            check(16'(n >= FRAME && n <= FRAME + 3), 16'h0001, "frame");
        end
    endtask : run_mode

    task automatic read_pair(input logic [7:0] ptr, input logic use_stop,
                             input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] rx;
        logic ack;
        alr_host_model_inst.start();
        alr_host_model_inst.xfer({ALR_DEV_ADDR, 1'b0}, 1'b0, rx, ack);
        check(16'(ack), 16'h0001, "write address ack");
        alr_host_model_inst.xfer(ptr, 1'b0, rx, ack);
        check(16'(ack), 16'h0001, "pointer ack");
        if (use_stop) begin
            alr_host_model_inst.stop();
        end
        alr_host_model_inst.start();
        alr_host_model_inst.xfer({ALR_DEV_ADDR, 1'b1}, 1'b0, rx, ack);
        check(16'(ack), 16'h0001, "read address ack");
        alr_host_model_inst.xfer(8'hff, 1'b1, rx, ack);
        check(16'(rx), 16'(e0), "first byte");
        alr_host_model_inst.xfer(8'hff, 1'b0, rx, ack);
        check(16'(rx), 16'(e1), "next byte");
        alr_host_model_inst.stop();
    endtask : read_pair

    // main sequence: reset, both modes at three counts, bus reads
    initial begin
        logic [7:0] rx;
        logic ack;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        check(result, ALR_RESULT_RESET, "result after reset");
        read_pair(ALR_PTR_RES_HI, 1'b1, 8'h00, 8'h00);
        for (int m = 0; m < 6; m++) begin
            run_mode(m[0], LGS[m >> 1]);
        end
        ctrl <= '0;
        repeat (4) @(posedge i_clk);
        read_pair(ALR_PTR_RES_HI, 1'b1, sample[15:8], sample[7:0]);
        read_pair(ALR_PTR_RES_LO, 1'b0, sample[7:0], ALR_UNMAPPED_DATA);
        alr_host_model_inst.start();
        alr_host_model_inst.xfer({ALR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, rx, ack);
        check(16'(ack), 16'h0000, "foreign address ack");
        alr_host_model_inst.stop();
        // a data byte after the pointer is not part of the access
        alr_host_model_inst.start();
        alr_host_model_inst.xfer({ALR_DEV_ADDR, 1'b0}, 1'b0, rx, ack);
        alr_host_model_inst.xfer(ALR_PTR_RES_HI, 1'b0, rx, ack);
        alr_host_model_inst.xfer(8'h5a, 1'b0, rx, ack);
        check(16'(ack), 16'h0000, "data byte after pointer");
        alr_host_model_inst.stop();
        // second reset in mid-run must clear the held result
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        check(result, ALR_RESULT_RESET, "result after second reset");
        summarize();
    end
endmodule : test_alr_readout

`default_nettype wire

// File: verilog/alr_pkg.sv
// shared constants and types of the ambient light readout block
// ****************************************************************
// ****************************************************************
`default_nettype none

package alr_pkg;

    // ************************************************************
    // bus addressing
    // ************************************************************
    localparam logic [6:0] ALR_DEV_ADDR = 7'h13; // 26h write, 27h read
    localparam logic [7:0] ALR_PTR_RES_HI = 8'h85;
    localparam logic [7:0] ALR_PTR_RES_LO = 8'h86;
    localparam logic [7:0] ALR_PTR_RESET = 8'h80;
    localparam logic [7:0] ALR_UNMAPPED_DATA = 8'h00;
    localparam logic [15:0] ALR_RESULT_RESET = 16'h0000;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int ALR_CLK_MHZ = 100;
    localparam int ALR_CONV_TIME_US = 300;
    localparam int ALR_FRAME_TIME_MS = 100;
    localparam int ALR_CONV_CYCLES = ALR_CONV_TIME_US * ALR_CLK_MHZ;
    localparam int ALR_FRAME_CYCLES = ALR_FRAME_TIME_MS * 1000 * ALR_CLK_MHZ;
    localparam int ALR_AVG_MAX = 128;
    localparam int ALR_AVG_LOG2_W = 3;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic enable;                      // run measurements
        logic continuous;                  // back to back conversions
        logic [ALR_AVG_LOG2_W-1:0] avg_log2; // average 2**n samples
    } alr_ctrl_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_CONV = 3'b010,
        SEQ_HOLD = 3'b100
    } alr_seq_state_t;

    typedef enum logic [6:0] {
        BUS_IDLE = 7'b000_0001,
        BUS_ADDR = 7'b000_0010,
        BUS_ACK_ADDR = 7'b000_0100,
        BUS_PTR = 7'b000_1000,
        BUS_ACK_PTR = 7'b001_0000,
        BUS_READ = 7'b010_0000,
        BUS_READ_ACK = 7'b100_0000
    } alr_bus_state_t;

endpackage : alr_pkg

`default_nettype wire

// File: verilog/alr_readout.sv
// ambient light readout top: serial bus target and result registers
`timescale 1ns/100ps
`default_nettype none

module alr_readout
    import alr_pkg::*;
#(
    parameter int CONV_CYCLES = ALR_CONV_CYCLES,
    parameter int FRAME_CYCLES = ALR_FRAME_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire alr_ctrl_t i_ctrl,
    input wire logic [15:0] i_light_sample,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [15:0] o_result,
    output logic o_result_stb
);

    alr_bus_state_t state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] bit_cnt_r;
    logic rw_r;
    logic nack_r;
    logic [7:0] ptr_r;
    logic [15:0] snap_r;
    logic [15:0] live_result;
    logic live_stb;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] tx_byte;

    // ************************************************************
    // conversion side
    // ************************************************************
    alr_sequencer #(
        .CONV_CYCLES(CONV_CYCLES),
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_seq (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ctrl(i_ctrl),
        .i_light_sample(i_light_sample),
        .o_result(live_result),
        .o_result_stb(live_stb)
    );

    // result mirrored to the user side
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_result <= ALR_RESULT_RESET;
            o_result_stb <= 1'b0;
        end else begin
            o_result <= live_result;
            o_result_stb <= live_stb;
        end
    end

    // ************************************************************
    // bus line sampling
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    // start/stop are data edges while clock stays high
    assign start_seen = i_scl && scl_q_r && sda_q_r && !i_sda;
    assign stop_seen = i_scl && scl_q_r && !sda_q_r && i_sda;
    assign scl_rise = i_scl && !scl_q_r;
    assign scl_fall = !i_scl && scl_q_r;

    // byte served for the current pointer, taken from the snapshot
    always_comb begin
        if (ptr_r == ALR_PTR_RES_HI) begin
            tx_byte = snap_r[15:8];
        end else if (ptr_r == ALR_PTR_RES_LO) begin
            tx_byte = snap_r[7:0];
        end else begin
            tx_byte = ALR_UNMAPPED_DATA;
        end
    end

    // snapshot is frozen during a read so high and low bytes match, except when a result lands as the first byte is loaded
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            snap_r <= ALR_RESULT_RESET;
        end else if (live_stb && state_r != BUS_READ &&
                     state_r != BUS_READ_ACK) begin
            snap_r <= live_result;
        end
    end

    // ************************************************************
    // bus target state machine
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= BUS_IDLE;
            shift_r <= '0;
            tx_r <= '0;
            bit_cnt_r <= '0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (start_seen) begin
            state_r <= BUS_ADDR; // repeated start also lands here
            bit_cnt_r <= '0;
            o_sda_oe <= 1'b0;
        end else if (stop_seen) begin
            state_r <= BUS_IDLE;
            o_sda_oe <= 1'b0;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                BUS_ADDR, BUS_PTR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], i_sda};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                    end else if (scl_fall && bit_cnt_r == 4'd8) begin
                        bit_cnt_r <= '0;
                        if (state_r == BUS_PTR) begin
                            o_sda_oe <= 1'b1; // ack pointer
                            state_r <= BUS_ACK_PTR;
                        end else if (shift_r[7:1] == ALR_DEV_ADDR) begin
                            o_sda_oe <= 1'b1;
                            rw_r <= shift_r[0];
                            state_r <= BUS_ACK_ADDR;
                        end else begin
                            state_r <= BUS_IDLE; // not our address
                        end
                    end
                end
                BUS_ACK_ADDR: begin
                    if (scl_fall && rw_r) begin
                        tx_r <= {tx_byte[6:0], 1'b0};
                        o_sda_oe <= ~tx_byte[7];
                        bit_cnt_r <= 4'd1;
                        state_r <= BUS_READ;
                    end else if (scl_fall) begin
                        o_sda_oe <= 1'b0;
                        state_r <= BUS_PTR;
                    end
                end
                BUS_ACK_PTR: begin
                    if (scl_fall) begin
                        o_sda_oe <= 1'b0; // no data byte expected
                        state_r <= BUS_IDLE;
                    end
                end
                BUS_READ: begin
                    if (scl_fall && bit_cnt_r == 4'd8) begin
                        o_sda_oe <= 1'b0;
                        state_r <= BUS_READ_ACK;
                    end else if (scl_fall) begin
                        o_sda_oe <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                    end
                end
                BUS_READ_ACK: begin
                    if (scl_rise) begin
                        nack_r <= i_sda;
                    end else if (scl_fall && nack_r) begin
                        state_r <= BUS_IDLE; // host ends the read
                    end else if (scl_fall) begin
                        tx_r <= {tx_byte[6:0], 1'b0};
                        o_sda_oe <= ~tx_byte[7];
                        bit_cnt_r <= 4'd1;
                        state_r <= BUS_READ;
                    end
                end
                default: begin
                    state_r <= BUS_IDLE;
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // register pointer: set by a write, stepped after each byte read
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ptr_r <= ALR_PTR_RESET;
        end else if (!start_seen && !stop_seen && state_r == BUS_PTR &&
                     scl_fall && bit_cnt_r == 4'd8) begin
            ptr_r <= shift_r;
        end else if (!start_seen && !stop_seen && state_r == BUS_READ &&
                     scl_fall && bit_cnt_r == 4'd8) begin
            ptr_r <= ptr_r + 8'd1;
        end
    end

    // open-drain line: only ever pulls low
    always_ff @(posedge i_clk) begin
        o_sda_out <= 1'b0;
    end

endmodule : alr_readout

`default_nettype wire

// File: verilog/alr_sequencer.sv
// conversion sequencing and averaging of the ambient light channel
`timescale 1ns/100ps
`default_nettype none

module alr_sequencer
    import alr_pkg::*;
#(
    parameter int CONV_CYCLES = ALR_CONV_CYCLES,
    parameter int FRAME_CYCLES = ALR_FRAME_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire alr_ctrl_t i_ctrl,
    input wire logic [15:0] i_light_sample,
    output logic [15:0] o_result,
    output logic o_result_stb
);

    alr_seq_state_t state_r;
    logic [31:0] conv_cnt_r;
    logic [31:0] frame_cnt_r;
    logic [7:0] taken_r;
    logic [22:0] acc_r;
    logic cont_r;
    logic [ALR_AVG_LOG2_W-1:0] log2_r;
    logic conv_end;
    logic last_conv;
    logic frame_end;
    logic [22:0] acc_sum;
    logic [22:0] avg_cont;
    logic [22:0] avg_std;

    // ************************************************************
    // conversion and frame timing
    // ************************************************************
    assign conv_end = (state_r == SEQ_CONV) &&
                      (conv_cnt_r == 32'(CONV_CYCLES - 1));
    assign last_conv = conv_end &&
                       (taken_r == 8'((1 << log2_r) - 1));
    assign frame_end = (frame_cnt_r == 32'(FRAME_CYCLES - 1));
    assign acc_sum = acc_r + 23'(i_light_sample);
    assign avg_cont = acc_sum >> log2_r;
    assign avg_std = acc_r >> log2_r;

    // state walk; mode and count are latched per cycle of averaging
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= SEQ_IDLE;
            cont_r <= 1'b0;
            log2_r <= '0;
        end else begin
            case (state_r)
                SEQ_IDLE: begin
                    if (i_ctrl.enable) begin
                        state_r <= SEQ_CONV;
                        cont_r <= i_ctrl.continuous;
                        log2_r <= i_ctrl.avg_log2;
                    end
                end
                SEQ_CONV: begin
                    if (!i_ctrl.enable) begin
                        state_r <= SEQ_IDLE;
                    end else if (last_conv && cont_r) begin
                        cont_r <= i_ctrl.continuous;
                        log2_r <= i_ctrl.avg_log2;
                        if (!i_ctrl.continuous) begin
                            state_r <= SEQ_IDLE;
                        end
                    end else if (last_conv) begin
                        state_r <= SEQ_HOLD;
                    end
                end
                SEQ_HOLD: begin
                    if (!i_ctrl.enable) begin
                        state_r <= SEQ_IDLE;
                    end else if (frame_end) begin
                        state_r <= SEQ_CONV; // next frame
                        cont_r <= i_ctrl.continuous;
                        log2_r <= i_ctrl.avg_log2;
                    end
                end
                default: begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    // conversion length counter
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state_r != SEQ_CONV || conv_end) begin
            conv_cnt_r <= '0;
        end else begin
            conv_cnt_r <= conv_cnt_r + 32'd1;
        end
    end

    // frame counter runs only in standard mode frames
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state_r == SEQ_IDLE || cont_r || frame_end) begin
            frame_cnt_r <= '0;
        end else begin
            frame_cnt_r <= frame_cnt_r + 32'd1;
        end
    end

    // accumulation; 23 bits hold 128 full-scale samples
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state_r == SEQ_IDLE) begin
            acc_r <= '0;
            taken_r <= '0;
        end else if (last_conv && cont_r) begin
            acc_r <= '0;
            taken_r <= '0;
        end else if (conv_end) begin
            acc_r <= acc_sum;
            taken_r <= taken_r + 8'd1;
        end else if (state_r == SEQ_HOLD && frame_end) begin
            acc_r <= '0;
            taken_r <= '0;
        end
    end

    // result publication
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_result <= ALR_RESULT_RESET;
            o_result_stb <= 1'b0;
        end else if (last_conv && cont_r) begin
            o_result <= avg_cont[15:0];
            o_result_stb <= 1'b1;
        end else if (state_r == SEQ_HOLD && frame_end) begin
            o_result <= avg_std[15:0];
            o_result_stb <= 1'b1;
        end else begin
            o_result_stb <= 1'b0;
        end
    end

endmodule : alr_sequencer

`default_nettype wire
